// [design/odsc_pkg.sv]
// shared constants and carriers for the octal driver serial control port
package odsc_pkg;
  localparam int FRAME_BITS     = 16;
  localparam int NUM_DRV        = 8;
  localparam int NUM_PIN        = 4;
  localparam int NUM_PAIR       = 4;
  localparam int CNT_W          = 4;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // response field positions
  localparam int RSP_TW_POS     = 0;
  localparam int RSP_DRV_LSB    = 1;
  localparam int RSP_PIN_LSB    = 9;
  localparam int RSP_SUP_POS    = 15;
  // command field positions
  localparam int CMD_EN_LSB     = 0;
  localparam int CMD_DIAG_LSB   = 8;
  localparam int PWM_FIRST_DRV  = 4;

  typedef struct packed {
    logic [NUM_DRV-1:0] diag_en;
    logic [NUM_DRV-1:0] drv_en;
  } odsc_cmd_s;

  typedef struct packed {
    logic                supply_fail;
    logic [1:0]          unused;
    logic [NUM_PIN-1:0]  pin_state;
    logic [NUM_DRV-1:0]  drv_fault;
    logic                thermal_warning_flag;
  } odsc_rsp_s;

  // analog sense inputs from the power stage
  typedef struct packed {
    logic [NUM_DRV-1:0]  open_load;
    logic [NUM_DRV-1:0]  over_current;
    logic [NUM_PAIR-1:0] over_temp;
    logic                thermal_warn;
    logic                supply_bad;
  } odsc_sense_s;
endpackage

// [design/odsc_top.sv]
// serial command and fault status port of an eight channel power driver
`timescale 1ns/1ps
// Operation
// RL1 - 16-bit words, lsb first, si in, so out
// RL2 - command bits 0-7 switch drivers on/off
// RL3 - command bits 8-15 enable open-load detection
// RL4 - response bits 1-8 report driver faults
// RL5 - response bits 9-12 mirror pwm pins
// RL6 - pin states captured on overcurrent/thermal shutdown
// RL7 - disabled driver flags only diagnosed open load (code also flags its pair's thermal shutdown)
// RL8 - overcurrent latched until frame disables driver
// RL9 - supply fail clears on frame, supply good
// RL10 - shutdown clears when cool and pair disabled
// RL11 - only multiple-of-16 clock frames are latched
// RL12 - multiples of 16 allow daisy chaining
// RL13 - counter armed by select fall, counts sclk
// RL14 - host holds sclk low at select rise
// RL15 - response bit 0 is thermal warning
// RL16 - response bit 15 latched supply fail
// RL17 - pwm channels on when serial or pin
// RL18 - rejected frames change and clear nothing
module odsc_top (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  input  wire logic                         sclk,
  input  wire logic                         select_bar_pin,
  input  wire logic                         si,
  output logic                              so,
  output logic                              so_oe,
  input  wire logic [odsc_pkg::NUM_PIN-1:0] pwm_pin,
  input  wire odsc_pkg::odsc_sense_s        sense,
  output logic [odsc_pkg::NUM_DRV-1:0]      drv_on,
  output logic [odsc_pkg::NUM_DRV-1:0]      diag_en
);

  // ---------------- link domain (sclk) ----------------
  logic [15:0]                    shift_reg;
  logic [15:0]                    out_reg;
  logic [odsc_pkg::CNT_W-1:0]     bit_cnt_reg;
  logic [odsc_pkg::CNT_W-1:0]     fall_cnt_reg;
  logic                           any_clk_reg;
  logic                           own_done_reg;
  logic [15:0]                    rsp_snap;

  // counter restarts on select fall, counts sclk rising edges
  always_ff @(posedge sclk or posedge select_bar_pin) begin
    if (select_bar_pin) begin
      bit_cnt_reg <= '0; // see RL13
      any_clk_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1; // see RL13
      any_clk_reg <= 1'b1;
    end
  end

  // lsb first: new bit enters at the top, last 16 bits kept
  always_ff @(posedge sclk) begin
    shift_reg <= {si, shift_reg[15:1]}; // see RL1
  end

  // chained devices forward received bits after their own 16
  logic si_pass_reg;
  always_ff @(posedge sclk) begin
    si_pass_reg <= si;
  end

  // received bits delayed by 16 falls for the next device in a chain
  always_ff @(negedge sclk or posedge select_bar_pin) begin
    if (select_bar_pin) begin
      out_reg <= 16'h0000;
    end else begin
      out_reg <= {si_pass_reg, out_reg[15:1]}; // see RL12
    end
  end

  // so moves only on sclk fall, never on the host's sampling edge
  always_ff @(negedge sclk or posedge select_bar_pin) begin
    if (select_bar_pin) begin
      fall_cnt_reg <= '0;
      own_done_reg <= 1'b0;
    end else begin
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
      if (fall_cnt_reg == '1) begin
        own_done_reg <= 1'b1; // see RL12
      end
    end
  end

  // snapshot of response, held in mclk domain, stable while select low
  logic [15:0] rsp_hold_reg;
  assign rsp_snap = rsp_hold_reg;
  // bit 0 (thermal warning) shows at select fall without any sclk
  always_comb begin
    if (own_done_reg) begin
      so = out_reg[0]; // see RL12
    end else begin
      so = rsp_snap[fall_cnt_reg]; // see RL1, RL15
    end
  end
  assign so_oe = ~select_bar_pin;

  // frame end: count wrapped to 0 with clocks seen means n*16 bits
  logic frame_ok_link;
  assign frame_ok_link = any_clk_reg && (bit_cnt_reg == '0); // see RL11

  // on select rise capture the word and toggle an event (host idles sclk low, see RL14)
  logic [15:0] cap_word_reg;
  logic        cap_tgl_reg;
  always_ff @(posedge select_bar_pin or negedge rstn) begin
    if (!rstn) begin
      cap_word_reg <= odsc_pkg::CMD_RESET;
      cap_tgl_reg  <= 1'b0;
    end else if (frame_ok_link) begin
      cap_word_reg <= shift_reg; // see RL11
      cap_tgl_reg  <= ~cap_tgl_reg;
    end
  end

  // ---------------- core domain (mclk) ----------------
  logic [2:0]                     tgl_sync_reg;
  logic [1:0]                     csb_sync_reg;
  logic [odsc_pkg::NUM_PIN-1:0]   pin_s1_reg;
  logic [odsc_pkg::NUM_PIN-1:0]   pin_s2_reg;
  logic                           frame_valid;
  logic [1:0]                     frame_dly_reg;
  odsc_pkg::odsc_cmd_s            cmd_reg;
  odsc_pkg::odsc_cmd_s            new_cmd;
  logic [odsc_pkg::NUM_DRV-1:0]   oc_latch_reg;
  logic [odsc_pkg::NUM_PAIR-1:0]  ts_latch_reg;
  logic                           sup_latch_reg;
  logic [odsc_pkg::NUM_PIN-1:0]   pin_capt_reg;
  logic                           pin_frozen_reg;
  logic [odsc_pkg::NUM_DRV-1:0]   drv_fault;
  logic [odsc_pkg::NUM_DRV-1:0]   pair_fault;
  odsc_pkg::odsc_rsp_s            rsp;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tgl_sync_reg <= '0;
      csb_sync_reg <= 2'b11;
      pin_s1_reg   <= '0;
      pin_s2_reg   <= '0;
    end else if (clk_en) begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], cap_tgl_reg};
      csb_sync_reg <= {csb_sync_reg[0], select_bar_pin};
      pin_s1_reg   <= pwm_pin;
      pin_s2_reg   <= pin_s1_reg;
    end
  end

  // word is stable for the whole toggle crossing, safe to sample
  assign frame_valid = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  assign new_cmd     = odsc_pkg::odsc_cmd_s'(cap_word_reg);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_reg <= odsc_pkg::odsc_cmd_s'(odsc_pkg::CMD_RESET);
    end else if (clk_en && frame_valid) begin
      cmd_reg <= new_cmd; // see RL18
    end
  end

  function automatic logic [odsc_pkg::NUM_DRV-1:0] pair_to_drv(input logic [odsc_pkg::NUM_PAIR-1:0] p);
    for (int i = 0; i < odsc_pkg::NUM_DRV; i++) begin
      pair_to_drv[i] = p[i/2];
    end
  endfunction

  // effective on command per channel
  logic [odsc_pkg::NUM_DRV-1:0] cmd_on;
  always_comb begin
    cmd_on = cmd_reg.drv_en;
    for (int i = 0; i < odsc_pkg::NUM_PIN; i++) begin
      cmd_on[odsc_pkg::PWM_FIRST_DRV+i] = cmd_reg.drv_en[odsc_pkg::PWM_FIRST_DRV+i] | pin_s2_reg[i]; // see RL17
    end
  end

  // latches: set wins over clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < odsc_pkg::NUM_DRV; g++) begin : g_oc
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          oc_latch_reg[g] <= 1'b0;
        end else if (clk_en) begin
          if (cmd_on[g] && sense.over_current[g]) begin
            oc_latch_reg[g] <= 1'b1; // see RL8
          end else if (frame_valid && !new_cmd.drv_en[g]) begin
            oc_latch_reg[g] <= 1'b0; // see RL8
          end
        end
      end
    end
    for (g = 0; g < odsc_pkg::NUM_PAIR; g++) begin : g_ts
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          ts_latch_reg[g] <= 1'b0;
        end else if (clk_en) begin
          if (sense.over_temp[g]) begin
            ts_latch_reg[g] <= 1'b1;
          end else if (frame_valid && !new_cmd.drv_en[2*g] && !new_cmd.drv_en[2*g+1]) begin
            ts_latch_reg[g] <= 1'b0; // see RL10
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sup_latch_reg <= 1'b0;
    end else if (clk_en) begin
      if (sense.supply_bad) begin
        sup_latch_reg <= 1'b1; // see RL16
      end else if (frame_valid) begin
        sup_latch_reg <= 1'b0; // see RL9
      end
    end
  end

  // pin mirror frozen by a protective shutoff until the latches clear
  logic any_trip;
  assign any_trip = |oc_latch_reg | (|ts_latch_reg);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_capt_reg   <= '0;
      pin_frozen_reg <= 1'b0;
    end else if (clk_en) begin
      pin_frozen_reg <= any_trip;
      if (!any_trip) begin
        pin_capt_reg <= pin_s2_reg; // see RL5
      end else if (!pin_frozen_reg) begin
        pin_capt_reg <= pin_s2_reg; // see RL6
      end
    end
  end

  assign pair_fault = pair_to_drv(ts_latch_reg);
  always_comb begin
    for (int i = 0; i < odsc_pkg::NUM_DRV; i++) begin
      if (cmd_on[i]) begin
        drv_fault[i] = oc_latch_reg[i] | pair_fault[i]; // see RL4
      end else begin
        drv_fault[i] = (cmd_reg.diag_en[i] & sense.open_load[i]) | pair_fault[i]; // see RL7
      end
    end
  end

  always_comb begin
    rsp.thermal_warning_flag = sense.thermal_warn; // see RL15
    rsp.drv_fault            = drv_fault;
    rsp.pin_state            = pin_capt_reg;
    rsp.unused               = 2'b00;
    rsp.supply_fail          = sup_latch_reg;
  end

  // response frozen while select low so the link sees a stable word
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsp_hold_reg <= 16'h0000;
    end else if (clk_en && csb_sync_reg[1]) begin
      rsp_hold_reg <= rsp;
    end
  end

  // outputs from flip-flops; shutoff forced by latches or bad supply
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drv_on  <= '0;
      diag_en <= '0;
    end else if (clk_en) begin
      drv_on  <= cmd_on & ~oc_latch_reg & ~pair_fault & {odsc_pkg::NUM_DRV{~sense.supply_bad}}; // see RL2
      diag_en <= cmd_reg.diag_en; // see RL3
    end
  end

  // ---------------- checks ----------------
  oc_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL8
    clk_en && oc_latch_reg[0] && !(frame_valid && !new_cmd.drv_en[0]) |=> oc_latch_reg[0])
    else $error("overcurrent latch dropped without a clearing frame");
  oc_clear_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL8
    clk_en && frame_valid && !new_cmd.drv_en[0] && !(cmd_on[0] && sense.over_current[0]) |=> !oc_latch_reg[0])
    else $error("overcurrent latch not cleared by frame");
  sup_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL9
    clk_en && sup_latch_reg && !frame_valid |=> sup_latch_reg)
    else $error("supply fail cleared without frame");
  sup_set_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL16
    clk_en && sense.supply_bad |=> sup_latch_reg)
    else $error("supply fail not latched");
  ts_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL10
    clk_en && ts_latch_reg[0] && sense.over_temp[0] |=> ts_latch_reg[0])
    else $error("shutdown latch cleared while hot");
  cmd_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL18
    clk_en && !frame_valid |=> $stable(cmd_reg))
    else $error("command changed without a valid frame");
  cmd_load_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL11
    clk_en && frame_valid |=> cmd_reg == $past(new_cmd))
    else $error("valid frame not latched");
  off_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL7
    !cmd_on[0] && !cmd_reg.diag_en[0] && !ts_latch_reg[0] |-> !drv_fault[0])
    else $error("disabled channel reports fault");
  pwm_or_a: assert property (@(posedge mclk) disable iff (!rstn) // see RL17
    clk_en && pin_s2_reg[0] && !oc_latch_reg[4] && !ts_latch_reg[2] && !sense.supply_bad |=> drv_on[4])
    else $error("pwm pin did not turn channel on");
  frame_c: cover property (@(posedge mclk) disable iff (!rstn) frame_valid);
  oc_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(oc_latch_reg[0]) ##[1:400] !oc_latch_reg[0]);
  sup_c: cover property (@(posedge mclk) disable iff (!rstn) $fell(sup_latch_reg));
endmodule

// [verification/odsc_host_model.sv]
// host controller model that drives the serial command port
`timescale 1ns/1ps
module odsc_host_model (
  output logic     sclk,
  output logic     select_bar_pin,
  output logic     si,
  input  wire logic so
);
  localparam time HALF = 40ns;

  // serial clock stands low outside frames; si idles at its pulldown level
  initial begin
    sclk = 1'b0;
    select_bar_pin = 1'b1;
    si = 1'b0;
  end

  // shift nbits of d lsb first; the first 16 bits seen on so are returned
  task automatic xfer(input int nbits, input logic [31:0] d, output logic [15:0] rsp);
    rsp = 16'h0000;
    #7ns;
    select_bar_pin = 1'b0;
    si = d[0];
    for (int k = 0; k < nbits; k++) begin
      #HALF;
      sclk = 1'b1;
      if (k < 16) rsp[k] = so;
      #HALF;
      sclk = 1'b0;
      si = (k + 1 < nbits) ? d[k+1] : 1'b0;
    end
    #HALF;
    select_bar_pin = 1'b1;
    si = 1'b0;
  endtask
endmodule

// [verification/octal_driver_spi_control_tb_top.sv]
// self-checking bench for the octal driver serial control port
`timescale 1ns/1ps
module octal_driver_spi_control_tb_top;
  logic                         mclk;
  logic                         rstn;
  logic                         clk_en;
  logic                         sclk;
  logic                         select_bar_pin;
  logic                         si;
  logic                         so;
  logic                         so_oe;
  logic [odsc_pkg::NUM_PIN-1:0] pwm_pin;
  odsc_pkg::odsc_sense_s        sense;
  logic [odsc_pkg::NUM_DRV-1:0] drv_on;
  logic [odsc_pkg::NUM_DRV-1:0] diag_en;
  logic [15:0]                  rsp;
  int                           n_fail;
  int                           samples_checked;

  odsc_top u_dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .sclk(sclk),
    .select_bar_pin(select_bar_pin), .si(si), .so(so), .so_oe(so_oe),
    .pwm_pin(pwm_pin), .sense(sense), .drv_on(drv_on), .diag_en(diag_en));

  odsc_host_model u_host (.sclk(sclk), .select_bar_pin(select_bar_pin), .si(si), .so(so));

  // so must be driven at every sampling edge of a frame
  always @(posedge sclk) begin
    if (so_oe !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t so not driven during frame", $time);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #12.5ns mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // gaps keep select high long enough for the response snapshot
  task automatic frm(input int n, input logic [31:0] d);
    repeat (10) @(negedge mclk);
    u_host.xfer(n, d, rsp);
    repeat (10) @(negedge mclk);
  endtask

  // response check with pin mirror bits masked where capture is ambiguous
  task automatic frc(input int n, input logic [31:0] d, input logic [15:0] exp, input logic [15:0] msk);
    frm(n, d);
    chk(rsp & msk, exp);
  endtask

  task automatic drv_chk(input logic [15:0] exp);
    chk({diag_en, drv_on}, exp);
  endtask

  initial begin
    #1ms;
    n_fail++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    pwm_pin = 4'h0;
    sense = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    drv_chk(16'h0000);
    chk({15'h0000, so_oe}, 16'h0000);
    frm(16, 32'h0000_a53c);
    drv_chk(16'ha53c);
    frm(15, 32'h0000_ffff);
    drv_chk(16'ha53c);
    frm(17, 32'h0001_ffff);
    drv_chk(16'ha53c);
    frm(32, 32'h5a0f_ffff);
    drv_chk(16'h5a0f);
    // open loads on disabled drivers, warning and pin mirror together
    sense.open_load = 8'hf0;
    sense.thermal_warn = 1'b1;
    pwm_pin = 4'b1010;
    frc(16, 32'h0000_5a0f, 16'h14a1, 16'hffff);
    drv_chk(16'h5aaf);
    sense = '0;
    frm(16, 32'h0000_0001);
    // short overcurrent while pins show 0101, pins drop before readout
    pwm_pin = 4'b0101;
    repeat (6) @(negedge mclk);
    sense.over_current[0] = 1'b1;
    repeat (4) @(negedge mclk);
    sense.over_current[0] = 1'b0;
    pwm_pin = 4'b0000;
    frc(16, 32'h0000_0001, 16'h0a02, 16'hffff);
    frm(17, 32'h0000_0000);
    frc(16, 32'h0000_0000, 16'h0002, 16'h81ff);
    frc(16, 32'h0000_0000, 16'h0000, 16'h81ff);
    // supply fail clears only once a frame ends with supply good
    sense.supply_bad = 1'b1;
    frc(16, 32'h0000_0000, 16'h8000, 16'h81ff);
    sense.supply_bad = 1'b0;
    frc(16, 32'h0000_0000, 16'h8000, 16'h81ff);
    frc(16, 32'h0000_0000, 16'h0000, 16'h81ff);
    // shutdown of pair one, hot frame must not clear it
    frm(16, 32'h0000_0001);
    sense.over_temp[0] = 1'b1;
    frc(16, 32'h0000_0000, 16'h0006, 16'h81ff);
    sense.over_temp[0] = 1'b0;
    frc(16, 32'h0000_0000, 16'h0006, 16'h81ff);
    frc(16, 32'h0000_0000, 16'h0000, 16'h81ff);
    end_of_test();
  end
endmodule
